// ### sbw_regs.sv
// Function
// - SDA input hold time is bits 6:4 in 50 ns steps, reset 0x1.
// - SCL and SDA glitches up to bits 3:0 x 10 ns are rejected, reset 0x7.
// - As master, SCL is held high for high count x 50 ns; reset 0x82.
// - Default high and low counts meet the minimum widths at a 26MHz clock.
// - As master, SCL is held low for low count x 50 ns; reset 0x82.
// - As slave, data stands for the low count before stretched SCL is freed.
// - Bits 2:1 of the test register select the forward clock, reset 0x0.
// - Bit 0 of the test register enables the link self test, reset zero.
// - A control transaction not done in bits 7:1 x 2ms is aborted; 0x7F.
// - Watchdog register bit 0 set to one disables the watchdog, reset zero.
// - In self test, back-channel CRC errors count in an 8-bit RO register.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "sbw_params.svh"
module sbw_regs import sbw_pkg::*; #(
  parameter int WD_UNIT_CYC = `SBW_WD_UNIT_NS / `SBW_CLK_NS
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // I2C pins
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  output logic scl_oe,
  // Internal I2C engine
  input wire logic m_run,
  input wire logic slv_stretch,
  input wire logic slv_data_rdy,
  output logic slv_released,
  output logic scl_filt,
  output logic sda_filt,
  // Control link
  input wire logic txn_active,
  output logic txn_abort,
  // Framer and self test
  input wire logic crc_err,
  output logic built_in_link_self_test_en,
  output logic [1:0] osc_sel,
  output logic [7:0] gp_bits,
  // Interrupt
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////

  localparam sbw_top_st_t RST_VAL = '{
    scl_sy: 2'h3,
    sda_sy: 2'h3,
    line: 20'hFFFFF,
    sda_f: 1'b1,
    scl_f: 1'b1,
    ctl: `SBW_CTL_RST,
    hi: `SBW_HIGH_RST,
    lo: `SBW_LOW_RST,
    gp: `SBW_GP_RST,
    osc: `SBW_OSC_RST,
    wd_tmo: `SBW_WD_TMO_RST,
    st: SBW_IDLE,
    default: '0
  };

  sbw_top_st_t st_r;
  sbw_top_st_t st_nxt;

  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic [23:0] wd_len;
  logic [3:0] filt_cyc;
  logic [4:0] hold_idx;
  logic scl_flt;
  logic sda_flt;
  logic [`SBW_N_IRQ-1:0] ev;
  logic [`SBW_N_IRQ-1:0] clr;

  sbw_cnt_if #(.W(24)) scl_cif ();
  sbw_cnt_if #(.W(24)) wd_cif ();

  // Steps round up to whole clocks so no pulse comes out short
  function automatic logic [15:0] to_cyc(input logic [7:0] n,
                                         input int step_ns);
    to_cyc = 16'((int'(n) * step_ns + `SBW_CLK_NS - 1) / `SBW_CLK_NS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign hi_len = (st_r.hi == 8'h00) ? 16'h0001 :
                  to_cyc(st_r.hi, `SBW_OSC_STEP_NS);
  assign lo_len = (st_r.lo == 8'h00) ? 16'h0001 :
                  to_cyc(st_r.lo, `SBW_OSC_STEP_NS);
  // A zero timeout would abort at once; it is run as one cycle
  assign wd_len = (st_r.wd_tmo == 7'h00) ? 24'h000001 :
                  24'(int'(st_r.wd_tmo) * WD_UNIT_CYC);
  assign filt_cyc = 4'(to_cyc({4'h0,
    st_r.ctl[`SBW_FILT_MSB:`SBW_FILT_LSB]}, `SBW_FILT_STEP_NS));
  assign hold_idx = 5'(to_cyc({5'h0,
    st_r.ctl[`SBW_HOLD_MSB:`SBW_HOLD_LSB]}, `SBW_OSC_STEP_NS));

  sbw_gflt u_flt_scl (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din(st_r.scl_sy[1]),
    .depth(filt_cyc),
    .dout(scl_flt)
  );

  sbw_gflt u_flt_sda (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din(st_r.sda_sy[1]),
    .depth(filt_cyc),
    .dout(sda_flt)
  );

  sbw_cnt #(.W(24)) u_scl_cnt (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .cif(scl_cif.cnt)
  );

  sbw_cnt #(.W(24)) u_wd_cnt (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .cif(wd_cif.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt = st_r;
    ev = '0;
    clr = '0;
    scl_cif.start = 1'b0;
    scl_cif.stop = 1'b0;
    scl_cif.len = 24'h000000;
    wd_cif.start = 1'b0;
    wd_cif.stop = 1'b0;
    wd_cif.len = wd_len;

    // Pin synchronisers, then filter, then hold delay on SDA
    st_nxt.scl_sy = {st_r.scl_sy[0], scl_pin_i};
    st_nxt.sda_sy = {st_r.sda_sy[0], sda_pin_i};
    st_nxt.scl_f = scl_flt;
    st_nxt.line = {st_r.line[18:0], sda_flt};
    st_nxt.sda_f = st_r.line[hold_idx];

    if (wr) begin
      case (addr)
        `SBW_ADDR_I2C_CTL: st_nxt.ctl = {1'b0, wdata[6:0]};
        `SBW_ADDR_SCL_HIGH: st_nxt.hi = wdata;
        `SBW_ADDR_SCL_LOW: st_nxt.lo = wdata;
        `SBW_ADDR_GP: st_nxt.gp = wdata;
        `SBW_ADDR_TEST: begin
          st_nxt.osc = wdata[`SBW_OSC_MSB:`SBW_OSC_LSB];
          st_nxt.built_in_link_self_test = wdata[`SBW_BUILT_IN_LINK_SELF_TEST_BIT];
        end
        `SBW_ADDR_WDOG: begin
          st_nxt.wd_tmo = wdata[`SBW_WD_TMO_MSB:`SBW_WD_TMO_LSB];
          st_nxt.wd_dis = wdata[`SBW_WD_DIS_BIT];
        end
        `SBW_ADDR_IRQ_CLR: clr = wdata[`SBW_N_IRQ-1:0];
        `SBW_ADDR_IRQ_EN: st_nxt.ien = wdata[`SBW_N_IRQ-1:0];
        default: ;
      endcase
    end

    // SCL timing; the master has priority over a slave release
    st_nxt.rel = 1'b0;
    unique case (st_r.st)
      SBW_IDLE: begin
        if (m_run) begin
          st_nxt.st = SBW_MLOW;
          scl_cif.start = 1'b1;
          scl_cif.len = 24'(lo_len);
        end else if (slv_data_rdy) begin
          st_nxt.st = SBW_SSETUP;
          scl_cif.start = 1'b1;
          scl_cif.len = 24'(lo_len);
        end
      end
      SBW_MLOW: begin
        if (scl_cif.done) begin
          st_nxt.st = SBW_MHIGH;
          scl_cif.start = 1'b1;
          scl_cif.len = 24'(hi_len);
        end
      end
      SBW_MHIGH: begin
        if (scl_cif.done && m_run) begin
          st_nxt.st = SBW_MLOW;
          scl_cif.start = 1'b1;
          scl_cif.len = 24'(lo_len);
        end else if (scl_cif.done) begin
          st_nxt.st = SBW_IDLE;
        end
      end
      SBW_SSETUP: begin
        if (scl_cif.done) begin
          st_nxt.st = SBW_IDLE;
          st_nxt.rel = 1'b1;
        end
      end
      default: begin
        st_nxt.st = SBW_IDLE;
        scl_cif.stop = 1'b1;
      end
    endcase
    st_nxt.scl_oe = (st_nxt.st == SBW_MLOW) ||
                    (st_nxt.st == SBW_SSETUP) ||
                    ((st_nxt.st == SBW_IDLE) && slv_stretch);

    // Watchdog arms on the start of a transaction, drops at its end
    st_nxt.txn_d = txn_active;
    st_nxt.abort = 1'b0;
    if (st_r.wd_dis || !txn_active) begin
      wd_cif.stop = 1'b1;
    end else if (!st_r.txn_d) begin
      wd_cif.start = 1'b1;
    end
    if (wd_cif.done) begin
      st_nxt.abort = 1'b1;
      ev[`SBW_IRQ_WDOG] = 1'b1;
    end

    // Error count; clearing on a fresh enable hides stale results
    if (st_nxt.built_in_link_self_test && !st_r.built_in_link_self_test) begin
      st_nxt.crc = 8'h00;
    end else if (st_r.built_in_link_self_test && crc_err) begin
      ev[`SBW_IRQ_CRC] = 1'b1;
      if (st_r.crc != 8'hFF) begin
        st_nxt.crc = st_r.crc + 8'h01;
        ev[`SBW_IRQ_SAT] = (st_r.crc == 8'hFE);
      end
    end

    // A new event wins over a clear in the same cycle
    st_nxt.sts = (st_r.sts & ~clr) | ev;
    st_nxt.irq = |(st_nxt.sts & st_nxt.ien);

    st_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `SBW_ADDR_I2C_CTL: st_nxt.rdata = st_r.ctl;
        `SBW_ADDR_SCL_HIGH: st_nxt.rdata = st_r.hi;
        `SBW_ADDR_SCL_LOW: st_nxt.rdata = st_r.lo;
        `SBW_ADDR_GP: st_nxt.rdata = st_r.gp;
        `SBW_ADDR_TEST: st_nxt.rdata = {5'h00, st_r.osc, st_r.built_in_link_self_test};
        `SBW_ADDR_WDOG: st_nxt.rdata = {st_r.wd_tmo, st_r.wd_dis};
        `SBW_ADDR_CRC: st_nxt.rdata = st_r.crc;
        `SBW_ADDR_IRQ_STS: st_nxt.rdata = 8'(st_r.sts);
        `SBW_ADDR_IRQ_EN: st_nxt.rdata = 8'(st_r.ien);
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= RST_VAL;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign rdata = st_r.rdata;
  assign scl_oe = st_r.scl_oe;
  assign slv_released = st_r.rel;
  assign scl_filt = st_r.scl_f;
  assign sda_filt = st_r.sda_f;
  assign txn_abort = st_r.abort;
  assign built_in_link_self_test_en = st_r.built_in_link_self_test;
  assign osc_sel = st_r.osc;
  assign gp_bits = st_r.gp;
  assign irq = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////

  // Cycle counters read only by the checks below
  logic [15:0] ph_r;
  logic [23:0] wcnt_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph_r <= 16'h0000;
      wcnt_r <= 24'h000000;
    end else if (ce) begin
      ph_r <= (st_nxt.st != st_r.st) ? 16'h0001 : ph_r + 16'h0001;
      if (wd_cif.start) begin
        wcnt_r <= 24'h000000;
      end else if (wd_cif.busy) begin
        wcnt_r <= wcnt_r + 24'h000001;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || !ce);

  a_hold_delay: assert property (
    (st_r.ctl[`SBW_HOLD_MSB:`SBW_HOLD_LSB] == 3'h1) [*5] |->
    st_r.sda_f == $past(sda_flt, 5))
    else $error("SDA hold delay wrong");
  a_scl_high: assert property (
    (st_r.st == SBW_MHIGH && st_nxt.st != SBW_MHIGH) |-> ph_r == hi_len)
    else $error("SCL high phase length wrong");
  a_dflt_width: assert property (
    (((st_r.hi == `SBW_HIGH_RST && st_r.st == SBW_MHIGH) ||
      (st_r.lo == `SBW_LOW_RST && st_r.st == SBW_MLOW)) &&
     st_nxt.st != st_r.st) |->
    32'(ph_r) * `SBW_CLK_NS * `SBW_OSC_NOM_MHZ >=
    `SBW_MIN_HIGH_NS * `SBW_OSC_FAST_MHZ)
    else $error("default SCL phase too short at fast clock");
  a_scl_low: assert property (
    (st_r.st == SBW_MLOW && st_nxt.st != SBW_MLOW) |->
    ph_r == lo_len && st_r.scl_oe)
    else $error("SCL low phase wrong");
  a_setup_rel: assert property (
    st_r.rel |-> $past(st_r.st) == SBW_SSETUP && $past(ph_r) == lo_len &&
    $past(st_r.scl_oe))
    else $error("slave setup interval wrong");
  a_osc_sel: assert property (
    (wr && addr == `SBW_ADDR_TEST) |=> osc_sel == $past(wdata[2:1]))
    else $error("clock source not taken");
  a_built_in_link_self_test_set: assert property (
    (wr && addr == `SBW_ADDR_TEST) |=> built_in_link_self_test_en == $past(wdata[0]))
    else $error("self test enable not taken");
  a_wd_abort: assert property (
    st_r.abort |-> wcnt_r == wd_len && $past(txn_active))
    else $error("watchdog abort at wrong time");
  a_wd_off: assert property (
    (st_r.wd_dis && $past(st_r.wd_dis)) |-> !st_r.abort)
    else $error("abort while watchdog disabled");
  a_crc_inc: assert property (
    (st_r.built_in_link_self_test && crc_err && st_r.crc != 8'hFF &&
     !(wr && addr == `SBW_ADDR_TEST)) |=> st_r.crc == $past(st_r.crc) + 8'h01)
    else $error("CRC error not counted");
  a_crc_sat: assert property (
    (st_r.crc == 8'hFF && !(wr && addr == `SBW_ADDR_TEST)) |=>
    st_r.crc == 8'hFF)
    else $error("CRC count wrapped");
  a_rd_once: assert property (
    !rd |=> rdata == 8'h00)
    else $error("read data outside answer cycle");

  c_master_period: cover property (
    st_r.st == SBW_MHIGH ##1 st_r.st == SBW_MLOW);
  c_slave_release: cover property (st_r.rel);
  c_wd_abort: cover property (st_r.abort);
  c_crc_sat: cover property ($rose(st_r.crc == 8'hFF));
endmodule

// ### sbw_params.svh
`ifndef SBW_PARAMS_SVH
`define SBW_PARAMS_SVH

// Register offsets
`define SBW_ADDR_I2C_CTL 8'h10
`define SBW_ADDR_SCL_HIGH 8'h11
`define SBW_ADDR_SCL_LOW 8'h12
`define SBW_ADDR_GP 8'h13
`define SBW_ADDR_TEST 8'h14
`define SBW_ADDR_WDOG 8'h1E
`define SBW_ADDR_CRC 8'h2A
`define SBW_ADDR_IRQ_STS 8'h40
`define SBW_ADDR_IRQ_CLR 8'h41
`define SBW_ADDR_IRQ_EN 8'h42

// Field positions
`define SBW_HOLD_MSB 6
`define SBW_HOLD_LSB 4
`define SBW_FILT_MSB 3
`define SBW_FILT_LSB 0
`define SBW_OSC_MSB 2
`define SBW_OSC_LSB 1
`define SBW_BUILT_IN_LINK_SELF_TEST_BIT 0
`define SBW_WD_TMO_MSB 7
`define SBW_WD_TMO_LSB 1
`define SBW_WD_DIS_BIT 0

// Reset values
`define SBW_HOLD_RST 3'h1
`define SBW_FILT_RST 4'h7
`define SBW_CTL_RST {1'b0, `SBW_HOLD_RST, `SBW_FILT_RST}
`define SBW_HIGH_RST 8'h82
`define SBW_LOW_RST 8'h82
`define SBW_GP_RST 8'h00
`define SBW_OSC_RST 2'h0
`define SBW_WD_TMO_RST 7'h7F

// Interrupt status bits
`define SBW_N_IRQ 3
`define SBW_IRQ_WDOG 0
`define SBW_IRQ_CRC 1
`define SBW_IRQ_SAT 2

// Timing, in ns
`define SBW_CLK_NS 20
`define SBW_OSC_STEP_NS 50
`define SBW_FILT_STEP_NS 10
`define SBW_WD_UNIT_NS 2000000
`define SBW_MIN_HIGH_NS 5000
// Oscillator nominal and worst fast frequency, in MHz
`define SBW_OSC_NOM_MHZ 20
`define SBW_OSC_FAST_MHZ 26

`endif

// ### sbw_pkg.sv
`include "sbw_params.svh"
package sbw_pkg;

  typedef enum logic [3:0] {
    SBW_IDLE = 4'b0001,
    SBW_MLOW = 4'b0010,
    SBW_MHIGH = 4'b0100,
    SBW_SSETUP = 4'b1000
  } sbw_scl_st_t;

  typedef struct packed {
    logic level;
    logic [3:0] run;
  } sbw_gflt_st_t;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [19:0] line;
    logic sda_f;
    logic scl_f;
    logic [7:0] ctl;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] gp;
    logic [1:0] osc;
    logic built_in_link_self_test;
    logic [6:0] wd_tmo;
    logic wd_dis;
    logic [7:0] crc;
    logic [`SBW_N_IRQ-1:0] sts;
    logic [`SBW_N_IRQ-1:0] ien;
    logic [7:0] rdata;
    logic irq;
    sbw_scl_st_t st;
    logic scl_oe;
    logic rel;
    logic txn_d;
    logic abort;
  } sbw_top_st_t;

endpackage

// ### sbw_cnt_if.sv
`timescale 1ns/10ps
interface sbw_cnt_if #(parameter int W = 24);
  logic start;
  logic stop;
  logic [W-1:0] len;
  logic done;
  logic busy;
  modport ctl (output start, output stop, output len, input done, input busy);
  modport cnt (input start, input stop, input len, output done, output busy);
endinterface

// ### sbw_cnt.sv
`timescale 1ns/10ps
module sbw_cnt #(parameter int W = 24) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Control
  sbw_cnt_if.cnt cif
);
  typedef struct packed {
    logic busy;
    logic [W-1:0] cnt;
  } sbw_cnt_st_t;

  sbw_cnt_st_t st_r;
  sbw_cnt_st_t st_nxt;

  // A zero length still runs one cycle so a phase never vanishes
  always_comb begin
    st_nxt = st_r;
    if (cif.stop) begin
      st_nxt.busy = 1'b0;
    end else if (cif.start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = (cif.len == '0) ? W'(1) : cif.len;
    end else if (st_r.busy) begin
      if (st_r.cnt == W'(1)) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign cif.busy = st_r.busy;
  assign cif.done = st_r.busy && (st_r.cnt == W'(1)) && !cif.stop;

  a_cnt_five: assert property (@(posedge clk_sys) disable iff (rst || !ce)
    (cif.start && !cif.stop && cif.len == W'(5)) ##1
    (!cif.start && !cif.stop)[*4] |=> cif.done)
    else $error("counter did not finish after five cycles");
endmodule

// ### sbw_gflt.sv
`timescale 1ns/10ps
module sbw_gflt import sbw_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Filter
  input wire logic din,
  input wire logic [3:0] depth,
  output logic dout
);
  sbw_gflt_st_t st_r;
  sbw_gflt_st_t st_nxt;

  // A level passes only after standing longer than depth cycles
  always_comb begin
    st_nxt = st_r;
    if (din == st_r.level) begin
      st_nxt.run = 4'h0;
    end else if (st_r.run >= depth) begin
      st_nxt.level = din;
      st_nxt.run = 4'h0;
    end else begin
      st_nxt.run = st_r.run + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '{level: 1'b1, run: 4'h0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.level;

  a_filt_width: assert property (
    @(posedge clk_sys) disable iff (rst || !ce)
    (st_r.level != $past(st_r.level)) |-> $past(st_r.run) >= $past(depth))
    else $error("glitch filter passed a short pulse");
endmodule

// ### sbw_far_model.sv
`timescale 1ns/10ps
module sbw_far_model (
  // Clock
  input wire logic clk_sys,
  // Device side of the open-drain pins
  input wire logic scl_oe,
  output logic scl_pin_i,
  output logic sda_pin_i
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;

  // Both lines have pull-ups: a released line reads high, never stale
  assign scl_pin_i = !(scl_oe || scl_low);
  assign sda_pin_i = !sda_low;

  // Far master pulls SDA, and SCL if asked, low for n cycles
  task automatic pull(input logic scl_too, input int n);
    @(posedge clk_sys);
    sda_low <= 1'b1;
    scl_low <= scl_too;
    repeat (n) @(posedge clk_sys);
    sda_low <= 1'b0;
    scl_low <= 1'b0;
  endtask
endmodule

// ### serializer_i2c_built_in_link_self_test_watchdog_regs_test.sv
`timescale 1ns/10ps
`include "sbw_params.svh"
module serializer_i2c_built_in_link_self_test_watchdog_regs_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic m_run = 1'b0;
  logic slv_stretch = 1'b0;
  logic slv_data_rdy = 1'b0;
  logic txn_active = 1'b0;
  logic crc_err = 1'b0;
  logic [7:0] rdata, gp_bits;
  logic [1:0] osc_sel;
  logic scl_oe, slv_released, scl_filt, sda_filt, txn_abort, built_in_link_self_test_en, irq;
  logic scl_pin_i, sda_pin_i;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 clk_sys = ~clk_sys;

  // Short watchdog unit keeps the timeout runs to a few cycles
  sbw_regs #(.WD_UNIT_CYC(4)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .scl_pin_i(scl_pin_i), .sda_pin_i(sda_pin_i), .scl_oe(scl_oe),
    .m_run(m_run), .slv_stretch(slv_stretch), .slv_data_rdy(slv_data_rdy),
    .slv_released(slv_released), .scl_filt(scl_filt), .sda_filt(sda_filt),
    .txn_active(txn_active), .txn_abort(txn_abort), .crc_err(crc_err),
    .built_in_link_self_test_en(built_in_link_self_test_en), .osc_sel(osc_sel), .gp_bits(gp_bits), .irq(irq));

  sbw_far_model far (.clk_sys(clk_sys), .scl_oe(scl_oe),
    .scl_pin_i(scl_pin_i), .sda_pin_i(sda_pin_i));

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut short well past the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {24'h0, rdata}, {24'h0, exp});
  endtask

  task automatic settle;
    repeat (2) @(negedge clk_sys);
  endtask

  // Counts negedges while scl_oe keeps level v
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (scl_oe === v && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task automatic wait_oe_high;
    int k;
    k = 0;
    while (scl_oe !== 1'b1 && k < 50) begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] a [11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h1E, 8'h2A,
                           8'h40, 8'h41, 8'h42, 8'h20};
    logic [7:0] e [11] = '{8'h17, 8'h82, 8'h82, 8'h00, 8'h00, 8'hFE, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rd_chk(a[i], e[i]);
    end
    chk("built_in_link_self_test_en", built_in_link_self_test_en, 0);
    chk("irq", irq, 0);
  endtask

  task automatic t_rw;
    wr_reg(`SBW_ADDR_I2C_CTL, 8'hFF);
    rd_chk(`SBW_ADDR_I2C_CTL, 8'h7F);
    wr_reg(`SBW_ADDR_I2C_CTL, 8'h17);
    wr_reg(`SBW_ADDR_GP, 8'hA5);
    settle();
    chk("gp_bits", gp_bits, 8'hA5);
    // With the enable low a write must not land
    @(posedge clk_sys);
    ce <= 1'b0;
    wr_reg(`SBW_ADDR_GP, 8'h5A);
    ce <= 1'b1;
    settle();
    chk("gp frozen", gp_bits, 8'hA5);
    wr_reg(`SBW_ADDR_CRC, 8'h55);
    rd_chk(`SBW_ADDR_CRC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SBW_ADDR_TEST, 8'(i << 1));
      settle();
      chk("osc_sel", osc_sel, i);
    end
    wr_reg(`SBW_ADDR_TEST, 8'hFF);
    rd_chk(`SBW_ADDR_TEST, 8'h07);
    chk("built_in_link_self_test_en", built_in_link_self_test_en, 1);
    wr_reg(`SBW_ADDR_TEST, 8'h00);
  endtask

  task automatic t_master(input int exp_l, input int exp_h);
    int l, h;
    @(posedge clk_sys);
    m_run <= 1'b1;
    wait_oe_high();
    run_len(1'b1, l);
    run_len(1'b0, h);
    chk("scl low", l, exp_l);
    chk("scl high", h, exp_h);
    @(posedge clk_sys);
    m_run <= 1'b0;
    repeat (exp_l + exp_h + 4) @(posedge clk_sys);
  endtask

  // Low count 2 gives a setup of ceil(2*50/20) = 5 cycles
  task automatic t_slave;
    int l;
    @(posedge clk_sys);
    slv_stretch <= 1'b1;
    settle();
    chk("stretch", scl_oe, 1);
    @(posedge clk_sys);
    slv_stretch <= 1'b0;
    slv_data_rdy <= 1'b1;
    @(posedge clk_sys);
    slv_data_rdy <= 1'b0;
    // Count from the first setup cycle, not the stretch before it
    @(negedge clk_sys);
    wait_oe_high();
    run_len(1'b1, l);
    chk("setup", l, 5);
    chk("released", slv_released, 1);
    @(negedge clk_sys);
    chk("released end", slv_released, 0);
  endtask

  // Timeout 2 with a 4-cycle unit gives T = 8 cycles
  task automatic t_wdog;
    int n;
    wr_reg(`SBW_ADDR_IRQ_CLR, 8'h07);
    wr_reg(`SBW_ADDR_IRQ_EN, 8'h01);
    wr_reg(`SBW_ADDR_WDOG, 8'h04);
    @(posedge clk_sys);
    txn_active <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (txn_abort !== 1'b1 && n < 100);
    chk("abort time", n, 10);
    @(negedge clk_sys);
    chk("abort pulse", txn_abort, 0);
    rd_chk(`SBW_ADDR_IRQ_STS, 8'h01);
    chk("irq set", irq, 1);
    wr_reg(`SBW_ADDR_IRQ_EN, 8'h00);
    settle();
    chk("irq masked", irq, 0);
    wr_reg(`SBW_ADDR_IRQ_EN, 8'h01);
    wr_reg(`SBW_ADDR_IRQ_CLR, 8'h01);
    settle();
    chk("irq cleared", irq, 0);
    txn_active <= 1'b0;
    wr_reg(`SBW_ADDR_WDOG, 8'h05);
    txn_active <= 1'b1;
    n = 0;
    repeat (30) begin
      @(negedge clk_sys);
      n += int'(txn_abort === 1'b1);
    end
    chk("disabled", n, 0);
    txn_active <= 1'b0;
    wr_reg(`SBW_ADDR_WDOG, 8'hFE);
  endtask

  task automatic crc_pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      crc_err <= 1'b1;
      @(posedge clk_sys);
      crc_err <= 1'b0;
    end
  endtask

  task automatic t_crc;
    crc_pulses(2);
    rd_chk(`SBW_ADDR_CRC, 8'h00);
    wr_reg(`SBW_ADDR_IRQ_CLR, 8'h07);
    wr_reg(`SBW_ADDR_TEST, 8'h01);
    crc_pulses(3);
    rd_chk(`SBW_ADDR_CRC, 8'h03);
    rd_chk(`SBW_ADDR_IRQ_STS, 8'h02);
    crc_pulses(300);
    rd_chk(`SBW_ADDR_CRC, 8'hFF);
    rd_chk(`SBW_ADDR_IRQ_STS, 8'h06);
    wr_reg(`SBW_ADDR_TEST, 8'h00);
    wr_reg(`SBW_ADDR_TEST, 8'h01);
    rd_chk(`SBW_ADDR_CRC, 8'h00);
    wr_reg(`SBW_ADDR_TEST, 8'h00);
    wr_reg(`SBW_ADDR_IRQ_CLR, 8'h07);
  endtask

  // Depth 7 rejects lows up to ceil(70/20) = 4 cycles
  task automatic t_glitch(input int len, input int exp_lows);
    int z;
    z = 0;
    fork
      far.pull(1'b0, len);
      repeat (40) begin
        @(negedge clk_sys);
        z += int'(sda_filt === 1'b0);
      end
    join
    chk("sda glitch", int'(z > 0), exp_lows);
  endtask

  task automatic skew(output int d);
    int ts, td;
    ts = -1;
    td = -1;
    fork
      far.pull(1'b1, 40);
      for (int i = 0; i < 60; i++) begin
        @(negedge clk_sys);
        if (ts < 0 && scl_filt === 1'b0) ts = i;
        if (td < 0 && sda_filt === 1'b0) td = i;
      end
    join
    d = td - ts;
    repeat (30) @(posedge clk_sys);
  endtask

  // Hold 3 adds ceil(150/20) - ceil(50/20) = 5 cycles over hold 1
  task automatic t_hold;
    int d1, d3;
    skew(d1);
    wr_reg(`SBW_ADDR_I2C_CTL, 8'h37);
    skew(d3);
    chk("hold skew", d3 - d1, 5);
    wr_reg(`SBW_ADDR_I2C_CTL, 8'h17);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_master(325, 325);
    wr_reg(`SBW_ADDR_SCL_LOW, 8'h02);
    wr_reg(`SBW_ADDR_SCL_HIGH, 8'h03);
    t_master(5, 8);
    t_slave();
    t_wdog();
    t_crc();
    t_glitch(4, 0);
    t_glitch(12, 1);
    t_hold();
    end_sim();
  end
endmodule
